// file: rtl/vimr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module vimr_regs #(
    parameter int unsigned NUM_SRC = vimr_pkg::NUM_SOURCES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // Bus slave port.
    input wire logic hsel,
    input wire vimr_pkg::vimr_addr_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire vimr_pkg::vimr_word_t hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output vimr_pkg::vimr_word_t hrdata,
    // Request lines from the sources, asynchronous to core_clk.
    input wire logic [NUM_SRC-1:0] raw_request_bits,
    // Handler address offered by the priority logic.
    input wire logic handler_valid,
    input wire vimr_pkg::vimr_word_t handler_addr_in,
    // Steering towards the priority logic and the processor.
    output logic [NUM_SRC-1:0] normal_status,
    output logic [NUM_SRC-1:0] fast_status,
    output logic normal_interrupt_output,
    output logic fast_interrupt_output,
    output logic handler_serviced,
    output logic handler_finished
);
    import vimr_pkg::*;

    logic [NUM_SRC-1:0] synced_request;
    logic [NUM_SRC-1:0] type_select_bits;
    logic [NUM_SRC-1:0] enable_bits;
    logic [NUM_SRC-1:0] soft_request_bits;
    logic [NUM_SRC-1:0] raw_source_status;
    logic [NUM_SRC-1:0] enabled_sources;
    logic protect_bit;
    vimr_word_t current_handler_address;

    // Data-phase state captured at the end of the address phase.
    vimr_reg_t dp_reg;
    logic dp_write;
    logic dp_read;
    logic dp_allowed;

    vimr_reg_t ap_reg;
    logic ap_valid;
    logic ap_allowed;
    logic wr_ok;
    logic rd_ok;

    function automatic vimr_reg_t decode_offset(input vimr_addr_t ofs);
        vimr_reg_t r;
        r = VIMR_REG_NONE;
        unique case (ofs)
            OFS_RAW_STATUS: r = VIMR_REG_RAW;
            OFS_TYPE_SELECT: r = VIMR_REG_SELECT;
            OFS_ENABLE_SET: r = VIMR_REG_EN_SET;
            OFS_ENABLE_CLEAR: r = VIMR_REG_EN_CLR;
            OFS_SOFT_SET: r = VIMR_REG_SOFT_SET;
            OFS_SOFT_CLEAR: r = VIMR_REG_SOFT_CLR;
            OFS_PROTECTION: r = VIMR_REG_PROT;
            OFS_HANDLER_ADDR: r = VIMR_REG_HANDLER;
            default: r = VIMR_REG_NONE;
        endcase
        return r;
    endfunction

    // Protection rules applied to one transfer.
    function automatic logic access_allowed(input vimr_reg_t r, input logic priv, input logic prot_on);
        logic ok;
        ok = 1'b1;
        if (r == VIMR_REG_PROT) begin
            ok = priv;
        end else if (prot_on) begin
            ok = priv;
        end else begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    vimr_sync #(
        .WIDTH(NUM_SRC)
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(raw_request_bits),
        .sync_out(synced_request)
    );

    // Software requests join the hardware ones ahead of all masking.
    assign raw_source_status = synced_request | soft_request_bits;
    assign enabled_sources = raw_source_status & enable_bits;

    // Address phase.
    assign ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign ap_reg = decode_offset(haddr);
    assign ap_allowed = access_allowed(ap_reg, hprot[HPROT_PRIV_BIT], protect_bit);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_reg <= VIMR_REG_NONE;
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_allowed <= 1'b0;
        end else if (hready) begin
            dp_reg <= ap_reg;
            dp_write <= ap_valid && hwrite;
            dp_read <= ap_valid && !hwrite;
            dp_allowed <= ap_allowed;
        end
    end

    // A blocked access leaves every register untouched.
    assign wr_ok = dp_write && dp_allowed;
    assign rd_ok = dp_read && dp_allowed;

    // Every access finishes in one data phase with an OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            type_select_bits <= '0;
        end else if (wr_ok && dp_reg == VIMR_REG_SELECT) begin
            type_select_bits <= hwdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_bits <= '0;
        end else if (wr_ok && dp_reg == VIMR_REG_EN_SET) begin
            enable_bits <= enable_bits | hwdata[NUM_SRC-1:0];
        end else if (wr_ok && dp_reg == VIMR_REG_EN_CLR) begin
            enable_bits <= enable_bits & ~hwdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_request_bits <= '0;
        end else if (wr_ok && dp_reg == VIMR_REG_SOFT_SET) begin
            soft_request_bits <= soft_request_bits | hwdata[NUM_SRC-1:0];
        end else if (wr_ok && dp_reg == VIMR_REG_SOFT_CLR) begin
            soft_request_bits <= soft_request_bits & ~hwdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            protect_bit <= 1'b0;
        end else if (wr_ok && dp_reg == VIMR_REG_PROT) begin
            protect_bit <= hwdata[PROT_BIT];
        end
    end

    // With no active interrupt the last handler address simply stays.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            current_handler_address <= HANDLER_RESET;
        end else if (handler_valid) begin
            current_handler_address <= handler_addr_in;
        end
    end

    // Serviced and finished are one-cycle pulses in the cycle after the data phase.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            handler_serviced <= 1'b0;
            handler_finished <= 1'b0;
        end else begin
            handler_serviced <= rd_ok && dp_reg == VIMR_REG_HANDLER && hready;
            handler_finished <= wr_ok && dp_reg == VIMR_REG_HANDLER && hready;
        end
    end

    // Steering outputs are registered so the processor sees glitch-free levels.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            normal_status <= '0;
            fast_status <= '0;
            normal_interrupt_output <= 1'b0;
            fast_interrupt_output <= 1'b0;
        end else begin
            normal_status <= enabled_sources & ~type_select_bits;
            fast_status <= enabled_sources & type_select_bits;
            normal_interrupt_output <= |(enabled_sources & ~type_select_bits);
            fast_interrupt_output <= |(enabled_sources & type_select_bits);
        end
    end

    // Read data is muxed from register state during the data phase, so no wait state is needed.
    always_comb begin
        hrdata = ZERO_WORD;
        if (rd_ok) begin
            unique case (dp_reg)
                VIMR_REG_RAW: hrdata[NUM_SRC-1:0] = raw_source_status;
                VIMR_REG_SELECT: hrdata[NUM_SRC-1:0] = type_select_bits;
                VIMR_REG_EN_SET: hrdata[NUM_SRC-1:0] = enable_bits;
                VIMR_REG_SOFT_SET: hrdata[NUM_SRC-1:0] = soft_request_bits;
                VIMR_REG_PROT: hrdata[PROT_BIT] = protect_bit;
                VIMR_REG_HANDLER: hrdata = current_handler_address;
                VIMR_REG_EN_CLR, VIMR_REG_SOFT_CLR, VIMR_REG_NONE: hrdata = ZERO_WORD;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: common/vimr_pkg.sv
// Contract
// - Raw status reads one bit per source, hardware or software, before enable masking.
// - Raw status follows the request lines, so its value after reset is undefined.
// - Type-select bit 0 routes a source to normal output, 1 to fast; reset 0.
// - Enable write sets bits written 1, ignores 0; reads show current enables.
// - Reset clears all enable bits so no source reaches either output.
// - A source drives its selected output only while its enable bit is 1.
// - Enable-clear write clears bits written 1, ignores 0; write-only.
// - Soft-request write sets bits written 1; reads show pending requests; reset 0.
// - Soft-clear write clears soft request bits written 1; write-only.
// - With protection bit 1, only transfers with privilege bit high are accepted.
// - With protection bit 0, user and privileged transfers are both accepted.
// - The protection register itself is reachable only by privileged transfers.
// - Protection bits 31 to 1 read zero; software leaves them unmodified.
// - All these registers complete without bus wait states.
// - Handler address register holds current active handler, else the last one.
// - Reading handler address marks interrupt serviced; any write marks it finished.
// - Request inputs pass a two-stage synchroniser before raw status.
package vimr_pkg;

    localparam int unsigned NUM_SOURCES = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    typedef logic [ADDR_W-1:0] vimr_addr_t;
    typedef logic [DATA_W-1:0] vimr_word_t;

    // Byte offsets of the register map.
    localparam vimr_addr_t OFS_RAW_STATUS = 12'h008;
    localparam vimr_addr_t OFS_TYPE_SELECT = 12'h00C;
    localparam vimr_addr_t OFS_ENABLE_SET = 12'h010;
    localparam vimr_addr_t OFS_ENABLE_CLEAR = 12'h014;
    localparam vimr_addr_t OFS_SOFT_SET = 12'h018;
    localparam vimr_addr_t OFS_SOFT_CLEAR = 12'h01C;
    localparam vimr_addr_t OFS_PROTECTION = 12'h020;
    localparam vimr_addr_t OFS_HANDLER_ADDR = 12'hF00;

    // Field positions and reset values.
    localparam int unsigned PROT_BIT = 0;
    localparam int unsigned HPROT_PRIV_BIT = 1;
    localparam vimr_word_t HANDLER_RESET = 32'h0000_0000;
    localparam vimr_word_t ZERO_WORD = 32'h0000_0000;

    // Transfer encodings of the bus.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [3:0] {
        VIMR_REG_NONE,
        VIMR_REG_RAW,
        VIMR_REG_SELECT,
        VIMR_REG_EN_SET,
        VIMR_REG_EN_CLR,
        VIMR_REG_SOFT_SET,
        VIMR_REG_SOFT_CLR,
        VIMR_REG_PROT,
        VIMR_REG_HANDLER
    } vimr_reg_t;

endpackage

// file: rtl/vimr_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for a bank of asynchronous request lines.
module vimr_sync #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_stage;

    // The first stage feeds only the second one, to give metastability a full period to settle.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_stage <= '0;
            sync_out <= '0;
        end else begin
            meta_stage <= async_in;
            sync_out <= meta_stage;
        end
    end

endmodule
`default_nettype wire

// file: sim/vimr_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module vimr_regs_chk #(
    parameter int unsigned NUM_SRC = 32
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire vimr_pkg::vimr_addr_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [3:0] hprot,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire vimr_pkg::vimr_word_t hrdata,
    input wire logic [NUM_SRC-1:0] normal_status,
    input wire logic [NUM_SRC-1:0] fast_status,
    input wire logic normal_interrupt_output,
    input wire logic fast_interrupt_output,
    input wire logic handler_serviced
);
    import vimr_pkg::*;
    logic tk;
    logic hrd;
    logic en_seen;
    assign tk = hsel && hready && htrans[1];
    assign hrd = tk && !hwrite && haddr == OFS_HANDLER_ADDR;
    // Outputs may only rise once software has written an enable at least once.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_seen <= 1'b0;
        end else if (tk && hwrite && haddr == OFS_ENABLE_SET) begin
            en_seen <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    no_wait_a: assert property (hreadyout) else $error("wait state inserted");
    okay_resp_a: assert property (hresp == HRESP_OKAY) else $error("non okay response");
    steer_disjoint_a: assert property (!(|(normal_status & fast_status))) else $error("source on both outputs");
    enclr_zero_a: assert property (tk && !hwrite && haddr == OFS_ENABLE_CLEAR |=> hrdata == ZERO_WORD)
        else $error("enable clear readable");
    softclr_zero_a: assert property (tk && !hwrite && haddr == OFS_SOFT_CLEAR |=> hrdata == ZERO_WORD)
        else $error("soft clear readable");
    prot_upper_a: assert property (tk && !hwrite && haddr == OFS_PROTECTION |=> hrdata[31:1] == 31'h0000_0000)
        else $error("protection upper bits set");
    prot_user_a: assert property (tk && !hwrite && haddr == OFS_PROTECTION && !hprot[1] |=> hrdata == ZERO_WORD)
        else $error("user read of protection");
    serviced_cause_a: assert property (handler_serviced |-> $past(hrd, 2)) else $error("stray serviced pulse");
    reset_masked_a: assert property (!en_seen |-> !normal_interrupt_output && !fast_interrupt_output)
        else $error("output before enable");
endmodule
bind vimr_regs vimr_regs_chk #(.NUM_SRC(NUM_SRC)) u_chk (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hprot, .hready, .hreadyout, .hresp, .hrdata, .normal_status, .fast_status, .normal_interrupt_output,
    .fast_interrupt_output, .handler_serviced);
`default_nettype wire

// file: sim/vimr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module vimr_core_model (
    input wire logic core_clk,
    output var logic hsel,
    output var vimr_pkg::vimr_addr_t haddr,
    output var logic [1:0] htrans,
    output var logic hwrite,
    output wire logic [2:0] hsize,
    output var logic [3:0] hprot,
    output var vimr_pkg::vimr_word_t hwdata,
    output wire logic hready
);
    import vimr_pkg::*;
    assign hready = 1'b1;
    assign hsize = 3'h2;
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hprot = 4'h1;
        hwdata = 32'h0000_0000;
    end
    // One single transfer; write data is garbage outside its data phase, as on a real bus.
    task automatic xfer(input logic wr, input vimr_addr_t a, input vimr_word_t d, input logic priv);
        @(posedge core_clk);
        #1;
        hsel = 1'b1;
        htrans = HTRANS_NONSEQ;
        haddr = a;
        hwrite = wr;
        hprot = {2'b00, priv, 1'b1};
        hwdata = ~d;
        @(posedge core_clk);
        #1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = d;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: sim/tb_vimr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_vimr_regs;
    import vimr_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel, hwrite, hready, hreadyout, hresp, handler_valid, rd_dp = 1'b0;
    logic normal_interrupt_output, fast_interrupt_output, handler_serviced, handler_finished;
    vimr_word_t normal_status, fast_status;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] hprot;
    vimr_addr_t haddr;
    vimr_word_t hwdata, hrdata, handler_addr_in, raw_request_bits, seed = 32'he735_2fc4, m1, m2, c, s, r, h;
    vimr_word_t exp_q[$];
    vimr_addr_t regs[7] = '{OFS_TYPE_SELECT, OFS_ENABLE_SET, OFS_SOFT_SET, OFS_PROTECTION, OFS_ENABLE_CLEAR,
        OFS_SOFT_CLEAR, 12'h004};
    int err_count = 0;
    int n_checks = 0;
    vimr_regs uut (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .raw_request_bits, .handler_valid, .handler_addr_in, .normal_status,
        .fast_status, .normal_interrupt_output, .fast_interrupt_output, .handler_serviced, .handler_finished);
    vimr_core_model u_core (.core_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hprot, .hwdata, .hready);
    always #5 core_clk = ~core_clk;
    function automatic vimr_word_t rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk(input string nm, input vimr_word_t seen, input vimr_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input vimr_addr_t a, input vimr_word_t d, input logic p);
        u_core.xfer(1'b1, a, d, p);
    endtask
    task automatic rd(input vimr_addr_t a, input logic p, input vimr_word_t e);
        exp_q.push_back(e);
        u_core.xfer(1'b0, a, ZERO_WORD, p);
    endtask
    // Request paths are synchronised, so let several edges pass before judging the outputs.
    task automatic outs(input vimr_word_t ns, input vimr_word_t fs);
        repeat (4) @(posedge core_clk);
        #1;
        chk("normal_status", normal_status, ns);
        chk("fast_status", fast_status, fs);
        chk("irq_outputs", {30'h0, normal_interrupt_output, fast_interrupt_output}, {30'h0, |ns, |fs});
    endtask
    task automatic end_of_test();
        chk("pending_reads", exp_q.size(), ZERO_WORD);
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (rd_dp) begin
            chk("hrdata", hrdata, exp_q.pop_front());
        end
        rd_dp <= rst_b && hsel && hready && htrans[1] && !hwrite;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        raw_request_bits = ZERO_WORD;
        handler_valid = 1'b0;
        handler_addr_in = ZERO_WORD;
        repeat (8) @(posedge core_clk);
        #1 rst_b = 1'b1;
        foreach (regs[i]) rd(regs[i], 1'b1, ZERO_WORD);
        r = rnd();
        #1 raw_request_bits = r;
        rd(OFS_RAW_STATUS, 1'b0, r);
        m1 = rnd();
        m2 = rnd();
        c = rnd();
        s = rnd();
        wr(OFS_ENABLE_SET, m1, 1'b1);
        wr(OFS_ENABLE_SET, m2, 1'b0);
        rd(OFS_ENABLE_SET, 1'b0, m1 | m2);
        wr(OFS_ENABLE_CLEAR, c, 1'b1);
        rd(OFS_ENABLE_SET, 1'b1, (m1 | m2) & ~c);
        wr(OFS_SOFT_SET, s, 1'b1);
        rd(OFS_SOFT_SET, 1'b1, s);
        rd(OFS_RAW_STATUS, 1'b1, r | s);
        wr(OFS_SOFT_CLEAR, c, 1'b1);
        rd(OFS_SOFT_SET, 1'b1, s & ~c);
        wr(OFS_ENABLE_CLEAR, 32'hFFFF_FFFF, 1'b1);
        wr(OFS_SOFT_CLEAR, 32'hFFFF_FFFF, 1'b1);
        #1 raw_request_bits = ZERO_WORD;
        wr(OFS_TYPE_SELECT, 32'h0000_0008, 1'b1);
        outs(ZERO_WORD, ZERO_WORD);
        wr(OFS_ENABLE_SET, 32'h0000_0018, 1'b1);
        wr(OFS_SOFT_SET, 32'h0000_0010, 1'b1);
        outs(32'h0000_0010, ZERO_WORD);
        wr(OFS_SOFT_SET, 32'h0000_0008, 1'b1);
        outs(32'h0000_0010, 32'h0000_0008);
        wr(OFS_ENABLE_CLEAR, 32'h0000_0019, 1'b1);
        outs(ZERO_WORD, ZERO_WORD);
        wr(OFS_ENABLE_SET, 32'h0000_0001, 1'b1);
        wr(OFS_PROTECTION, 32'hFFFF_FFFF, 1'b1);
        rd(OFS_PROTECTION, 1'b1, 32'h0000_0001);
        wr(OFS_ENABLE_SET, 32'hFFFF_FFFF, 1'b0);
        rd(OFS_ENABLE_SET, 1'b0, ZERO_WORD);
        rd(OFS_ENABLE_SET, 1'b1, 32'h0000_0001);
        wr(OFS_PROTECTION, ZERO_WORD, 1'b0);
        rd(OFS_PROTECTION, 1'b0, ZERO_WORD);
        rd(OFS_PROTECTION, 1'b1, 32'h0000_0001);
        wr(OFS_PROTECTION, ZERO_WORD, 1'b1);
        wr(OFS_PROTECTION, 32'h0000_0001, 1'b0);
        rd(OFS_PROTECTION, 1'b1, ZERO_WORD);
        h = rnd();
        #1 handler_valid = 1'b1;
        handler_addr_in = h;
        @(posedge core_clk);
        #1 handler_valid = 1'b0;
        handler_addr_in = ~h;
        rd(OFS_HANDLER_ADDR, 1'b0, h);
        #1 chk("handler_serviced", {31'h0, handler_serviced}, 32'h0000_0001);
        wr(OFS_HANDLER_ADDR, ZERO_WORD, 1'b0);
        #1 chk("handler_finished", {31'h0, handler_finished}, 32'h0000_0001);
        @(posedge core_clk);
        #1 chk("pulse_ends", {30'h0, handler_serviced, handler_finished}, ZERO_WORD);
        repeat (3) @(posedge core_clk);
        end_of_test();
    end
endmodule
`default_nettype wire
